// ---- rtl/pebu_extend.sv ----
module pebu_extend
  import pebu_pkg::*;
(
  input  wire logic [DATA_W-1:0] src_i,
  input  wire logic [1:0]        rot_sel_i,
  input  wire logic              is_signed_i,
  input  wire logic [1:0]        size_i,
  output logic      [DATA_W-1:0] ext_o
);

  logic [DATA_W-1:0] rot;
  logic [15:0]       lo16;
  logic [15:0]       hi16;

  // ----------------------------------------------------------------
  // Rotate then extract
  // ----------------------------------------------------------------
  always_comb begin
    unique case (rot_sel_i)
      2'h0: rot = src_i;
      2'h1: rot = {src_i[7:0],   src_i[31:8]};
      2'h2: rot = {src_i[15:0],  src_i[31:16]};
      2'h3: rot = {src_i[23:0],  src_i[31:24]};
    endcase
    lo16 = {{8{is_signed_i & rot[7]}},  rot[7:0]};
    hi16 = {{8{is_signed_i & rot[23]}}, rot[23:16]};
    unique case (size_i)
      2'h0:    ext_o = {{24{is_signed_i & rot[7]}}, rot[7:0]};
      2'h1:    ext_o = {{16{is_signed_i & rot[15]}}, rot[15:0]};
      default: ext_o = {hi16, lo16};
    endcase
  end

endmodule : pebu_extend

// ---- rtl/pebu_field.sv ----
module pebu_field
  import pebu_pkg::*;
(
  input  wire logic [DATA_W-1:0]  dest_i,
  input  wire logic [DATA_W-1:0]  src_i,
  input  wire logic [SHIFT_W-1:0] lsb_i,
  input  wire logic [5:0]         width_i,
  input  wire logic               insert_i,
  output logic      [DATA_W-1:0]  res_o
);

  logic [DATA_W-1:0] span;
  logic [DATA_W:0]   ones;

  // Width of 32 needs a 33-bit intermediate to avoid overflow
  always_comb begin
    ones  = (33'h000000001 << width_i) - 33'h000000001;
    span  = ones[DATA_W-1:0] << lsb_i;
    if (insert_i) begin
      res_o = (dest_i & ~span) | ((src_i << lsb_i) & span);
    end else begin
      res_o = dest_i & ~span;
    end
  end

endmodule : pebu_field

// ---- rtl/pebu_pkg.sv ----
// Operation
// - Bottom-top pack: low half of first operand, high half of shifted second.
// - Bottom-top pack left shift 1 to 31; zero means unshifted.
// - Top-bottom pack: high half of first operand, low half of shifted second.
// - Top-bottom pack arithmetic right shift 1 to 32; encoded zero means 32.
// - Without a given destination, pack and extend-add write to first operand register.
// - None of these operations modify condition flags.
// - Extend-add rotates second operand right by 0, 8, 16 or 24.
// - Byte extend-add extends low byte to 32 bits and adds first operand.
// - Half extend-add extends low 16 bits to 32 and adds first operand.
// - Dual extend-add extends bytes zero and two, adds each halfword independently.
// - Extend-add sum goes to full word or matching halfword, then destination.
// - Extend-only rotates its source right by 0, 8, 16 or 24.
// - Byte and half extend-only output low 8 or 16 bits extended to 32.
// - Dual extend-only puts extended byte zero low and byte two high.
// - Field clear zeroes the chosen span and keeps other destination bits.
// - Field insert copies source low bits into the span, others kept.
package pebu_pkg;

  localparam int unsigned DATA_W      = 32;
  localparam int unsigned HALF_W      = 16;
  localparam int unsigned SHIFT_W     = 5;
  localparam int unsigned REG_IDX_W   = 4;
  localparam logic [1:0]  ROT_NONE    = 2'h0;
  localparam logic [4:0]  SAR_ENC_32  = 5'h00;
  localparam logic [5:0]  SAR_FULL    = 6'h20;
  localparam int unsigned LATENCY     = 1;

  typedef enum logic [4:0] {
    PEBU_OP_PACK_BT,
    PEBU_OP_PACK_TB,
    PEBU_OP_SIGNED_BYTE_EXTEND_ADD,
    PEBU_OP_SIGNED_HALF_EXTEND_ADD,
    PEBU_OP_SIGNED_DUAL_BYTE_EXTEND_ADD,
    PEBU_OP_UNSIGNED_BYTE_EXTEND_ADD,
    PEBU_OP_UNSIGNED_HALF_EXTEND_ADD,
    PEBU_OP_UNSIGNED_DUAL_BYTE_EXTEND_ADD,
    PEBU_OP_SIGNED_BYTE_EXTEND,
    PEBU_OP_SIGNED_HALF_EXTEND,
    PEBU_OP_SIGNED_DUAL_BYTE_EXTEND,
    PEBU_OP_UNSIGNED_BYTE_EXTEND,
    PEBU_OP_UNSIGNED_HALF_EXTEND,
    PEBU_OP_UNSIGNED_DUAL_BYTE_EXTEND,
    PEBU_OP_FIELD_CLEAR,
    PEBU_OP_FIELD_INSERT
  } pebu_op_t;

  typedef struct packed {
    pebu_op_t               op;
    logic [SHIFT_W-1:0]     shift_amt;
    logic [1:0]             rot_sel;
    logic [SHIFT_W-1:0]     field_lsb;
    logic [5:0]             field_width;
    logic                   dest_given;
    logic [REG_IDX_W-1:0]   dest_idx;
    logic [REG_IDX_W-1:0]   first_idx;
    logic [DATA_W-1:0]      first_operand;
    logic [DATA_W-1:0]      second_operand;
    logic [DATA_W-1:0]      dest_value;
  } pebu_req_t;

  typedef struct packed {
    logic                   valid;
    logic [REG_IDX_W-1:0]   wr_idx;
    logic [DATA_W-1:0]      data;
    logic                   flags_we;
  } pebu_rsp_t;

endpackage : pebu_pkg

// ---- rtl/pebu_top.sv ----
module pebu_top
  import pebu_pkg::*;
(
  input  wire logic                 SYS_CLK_I,
  input  wire logic                 SYS_RST_I,
  input  wire logic                 REQ_VALID_I,
  input  wire pebu_req_t            REQ_I,
  output pebu_rsp_t                 RSP_O
);

  logic [DATA_W-1:0] ext_val;
  logic [DATA_W-1:0] fld_val;
  logic [DATA_W-1:0] shl;
  logic [DATA_W-1:0] sar;
  logic [DATA_W-1:0] res_nxt;
  logic [5:0]        sar_amt;
  logic              is_signed;
  logic [1:0]        ext_size;
  logic              is_add;
  logic              uses_default_dest;
  pebu_rsp_t         rsp_r;

  // ----------------------------------------------------------------
  // Operation classification
  // ----------------------------------------------------------------
  function automatic logic op_signed(input pebu_op_t op);
    return op inside {PEBU_OP_SIGNED_BYTE_EXTEND_ADD, PEBU_OP_SIGNED_HALF_EXTEND_ADD,
                      PEBU_OP_SIGNED_DUAL_BYTE_EXTEND_ADD, PEBU_OP_SIGNED_BYTE_EXTEND,
                      PEBU_OP_SIGNED_HALF_EXTEND, PEBU_OP_SIGNED_DUAL_BYTE_EXTEND};
  endfunction : op_signed

  function automatic logic [1:0] op_size(input pebu_op_t op);
    unique case (op)
      PEBU_OP_SIGNED_BYTE_EXTEND_ADD, PEBU_OP_UNSIGNED_BYTE_EXTEND_ADD,
      PEBU_OP_SIGNED_BYTE_EXTEND, PEBU_OP_UNSIGNED_BYTE_EXTEND:       return 2'h0;
      PEBU_OP_SIGNED_HALF_EXTEND_ADD, PEBU_OP_UNSIGNED_HALF_EXTEND_ADD,
      PEBU_OP_SIGNED_HALF_EXTEND, PEBU_OP_UNSIGNED_HALF_EXTEND:       return 2'h1;
      default:                                                        return 2'h2;
    endcase
  endfunction : op_size

  function automatic logic op_add(input pebu_op_t op);
    return op inside {PEBU_OP_SIGNED_BYTE_EXTEND_ADD, PEBU_OP_SIGNED_HALF_EXTEND_ADD,
                      PEBU_OP_SIGNED_DUAL_BYTE_EXTEND_ADD, PEBU_OP_UNSIGNED_BYTE_EXTEND_ADD,
                      PEBU_OP_UNSIGNED_HALF_EXTEND_ADD, PEBU_OP_UNSIGNED_DUAL_BYTE_EXTEND_ADD};
  endfunction : op_add

  assign is_signed = op_signed(REQ_I.op);
  assign ext_size  = op_size(REQ_I.op);
  assign is_add    = op_add(REQ_I.op);

  // ----------------------------------------------------------------
  // Sub-units
  // ----------------------------------------------------------------
  pebu_extend u_extend (
    .src_i       (is_add ? REQ_I.second_operand : REQ_I.first_operand),
    .rot_sel_i   (REQ_I.rot_sel),
    .is_signed_i (is_signed),
    .size_i      (ext_size),
    .ext_o       (ext_val)
  );

  pebu_field u_field (
    .dest_i   (REQ_I.dest_value),
    .src_i    (REQ_I.first_operand),
    .lsb_i    (REQ_I.field_lsb),
    .width_i  (REQ_I.field_width),
    .insert_i (REQ_I.op == PEBU_OP_FIELD_INSERT),
    .res_o    (fld_val)
  );

  // ----------------------------------------------------------------
  // Pack shifters
  // ----------------------------------------------------------------
  // Encoded zero for the right shift stands for a full 32-bit shift
  assign sar_amt = (REQ_I.shift_amt == SAR_ENC_32) ? SAR_FULL : {1'b0, REQ_I.shift_amt};
  assign shl     = REQ_I.second_operand << REQ_I.shift_amt;
  assign sar     = (sar_amt == SAR_FULL) ? {DATA_W{REQ_I.second_operand[DATA_W-1]}}
                                         : DATA_W'($signed(REQ_I.second_operand) >>> sar_amt);

  // ----------------------------------------------------------------
  // Result select
  // ----------------------------------------------------------------
  always_comb begin
    unique case (REQ_I.op)
      PEBU_OP_PACK_BT: res_nxt = {shl[31:16], REQ_I.first_operand[15:0]};
      PEBU_OP_PACK_TB: res_nxt = {REQ_I.first_operand[31:16], sar[15:0]};
      PEBU_OP_SIGNED_BYTE_EXTEND_ADD, PEBU_OP_SIGNED_HALF_EXTEND_ADD,
      PEBU_OP_UNSIGNED_BYTE_EXTEND_ADD, PEBU_OP_UNSIGNED_HALF_EXTEND_ADD:
        res_nxt = REQ_I.first_operand + ext_val;
      PEBU_OP_SIGNED_DUAL_BYTE_EXTEND_ADD, PEBU_OP_UNSIGNED_DUAL_BYTE_EXTEND_ADD:
        // Halves add separately, so no carry crosses bit 16
        res_nxt = {REQ_I.first_operand[31:16] + ext_val[31:16],
                   REQ_I.first_operand[15:0]  + ext_val[15:0]};
      PEBU_OP_SIGNED_BYTE_EXTEND, PEBU_OP_SIGNED_HALF_EXTEND, PEBU_OP_SIGNED_DUAL_BYTE_EXTEND,
      PEBU_OP_UNSIGNED_BYTE_EXTEND, PEBU_OP_UNSIGNED_HALF_EXTEND, PEBU_OP_UNSIGNED_DUAL_BYTE_EXTEND:
        res_nxt = ext_val;
      default: res_nxt = fld_val;
    endcase
  end

  assign uses_default_dest = (REQ_I.op inside {PEBU_OP_PACK_BT, PEBU_OP_PACK_TB}) || is_add;

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  // Only the pipeline stage is held; nothing carries between operations
  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      rsp_r <= '0;
    end else begin
      rsp_r.valid    <= REQ_VALID_I;
      rsp_r.data     <= res_nxt;
      rsp_r.wr_idx   <= (uses_default_dest && !REQ_I.dest_given) ? REQ_I.first_idx
                                                                 : REQ_I.dest_idx;
      rsp_r.flags_we <= 1'b0;
    end
  end

  assign RSP_O = rsp_r;

endmodule : pebu_top

// ---- testbench/pebu_monitor.sv ----
module pebu_monitor
  import pebu_pkg::*;
(
  input wire logic      SYS_CLK_I,
  input wire logic      SYS_RST_I,
  input wire logic      REQ_VALID_I,
  input wire pebu_req_t REQ_I,
  input wire pebu_rsp_t RSP_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic [31:0] bt_w;
  logic [31:0] tb_w;
  logic [63:0] r1_w;
  logic [63:0] r2_w;
  logic [63:0] msk_w;
  logic [31:0] ins_w;
  // Right-shift code zero means a full-width shift, so widen the amount first
  assign bt_w = REQ_I.second_operand << REQ_I.shift_amt;
  assign tb_w = $signed(REQ_I.second_operand) >>> ((REQ_I.shift_amt == 5'h00) ? 6'h20 : {1'b0, REQ_I.shift_amt});
  assign r1_w = {REQ_I.first_operand, REQ_I.first_operand} >> {REQ_I.rot_sel, 3'h0};
  assign r2_w = {REQ_I.second_operand, REQ_I.second_operand} >> {REQ_I.rot_sel, 3'h0};
  assign msk_w = ((64'h1 << REQ_I.field_width) - 64'h1) << REQ_I.field_lsb;
  // Inside the span a clear gives zeros and an insert the source moved up to the low position
  assign ins_w = (REQ_I.op == PEBU_OP_FIELD_INSERT) ? REQ_I.first_operand << REQ_I.field_lsb : 32'h00000000;
  rsp_taken_a: assert property (REQ_VALID_I |=> RSP_O.valid) else $error("no response");
  rsp_spurious_a: assert property (!REQ_VALID_I |=> !RSP_O.valid) else $error("stray response");
  flags_kept_a: assert property (!RSP_O.flags_we) else $error("flags written");
  dest_default_a: assert property (REQ_VALID_I && !REQ_I.dest_given
    && REQ_I.op <= PEBU_OP_UNSIGNED_DUAL_BYTE_EXTEND_ADD |=> RSP_O.wr_idx == $past(REQ_I.first_idx))
    else $error("wrong write index");
  pack_bt_a: assert property (REQ_VALID_I && REQ_I.op == PEBU_OP_PACK_BT
    |=> RSP_O.data == {$past(bt_w[31:16]), $past(REQ_I.first_operand[15:0])}) else $error("bad bt pack");
  pack_tb_a: assert property (REQ_VALID_I && REQ_I.op == PEBU_OP_PACK_TB
    |=> RSP_O.data == {$past(REQ_I.first_operand[31:16]), $past(tb_w[15:0])}) else $error("bad tb pack");
  byte_extend_a: assert property (REQ_VALID_I && REQ_I.op == PEBU_OP_SIGNED_BYTE_EXTEND
    |=> RSP_O.data == $past({{24{r1_w[7]}}, r1_w[7:0]})) else $error("bad byte extend");
  half_add_a: assert property (REQ_VALID_I && REQ_I.op == PEBU_OP_SIGNED_HALF_EXTEND_ADD
    |=> RSP_O.data == $past(REQ_I.first_operand + {{16{r2_w[15]}}, r2_w[15:0]})) else $error("bad half add");
  field_keep_a: assert property (REQ_VALID_I && REQ_I.op >= PEBU_OP_FIELD_CLEAR
    |=> (RSP_O.data & ~$past(msk_w[31:0])) == ($past(REQ_I.dest_value) & ~$past(msk_w[31:0])))
    else $error("field outside span changed");
  field_span_a: assert property (REQ_VALID_I && REQ_I.op >= PEBU_OP_FIELD_CLEAR
    |=> (RSP_O.data & $past(msk_w[31:0])) == $past(ins_w & msk_w[31:0])) else $error("field span wrong");
endmodule : pebu_monitor

bind pebu_top pebu_monitor u_pebu_monitor (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I),
  .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I), .RSP_O(RSP_O));

// ---- testbench/pebu_regfile.sv ----
module pebu_regfile
  import pebu_pkg::*;
(
  input  wire logic      clk_i,
  input  wire pebu_rsp_t rsp_i,
  output logic [DATA_W-1:0] regs_o [16]
);
  timeunit 1ns;
  timeprecision 1ps;
  // Flags live on this side; the unit never asks for them
  always_ff @(posedge clk_i) begin
    if (rsp_i.valid) begin
      regs_o[rsp_i.wr_idx] <= rsp_i.data;
    end
  end
endmodule : pebu_regfile

// ---- testbench/testbench.sv ----
module testbench
  import pebu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    pebu_op_t    op;
    logic [4:0]  amt;
    logic [5:0]  wid;
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] exp;
  } pebu_row_t;
  localparam logic [31:0] op_a = 32'h12348001;
  localparam logic [31:0] ones = 32'hFFFFFFFF;
  localparam logic [31:0] zero = 32'h00000000;
  logic        SYS_CLK_I = 1'b0;
  logic        SYS_RST_I = 1'b1;
  logic        REQ_VALID_I = 1'b0;
  pebu_req_t   REQ_I = '0;
  pebu_rsp_t   RSP_O;
  logic [31:0] regs [16];
  int          n_mismatch = 0;
  int          checks = 0;
  // Amount column feeds shift, rotate and field position alike
  pebu_row_t rows [19] = '{
    '{PEBU_OP_PACK_BT, 5'h04, 6'h00, op_a, zero, 32'h0F078001},
    '{PEBU_OP_PACK_BT, 5'h00, 6'h00, op_a, zero, 32'h80F08001},
    '{PEBU_OP_PACK_TB, 5'h00, 6'h00, op_a, zero, 32'h1234FFFF},
    '{PEBU_OP_PACK_TB, 5'h04, 6'h00, op_a, zero, 32'h123407F8},
    '{PEBU_OP_SIGNED_BYTE_EXTEND_ADD, 5'h01, 6'h00, op_a, zero, 32'h12348080},
    '{PEBU_OP_SIGNED_HALF_EXTEND_ADD, 5'h02, 6'h00, op_a, zero, 32'h123400F1},
    '{PEBU_OP_SIGNED_DUAL_BYTE_EXTEND_ADD, 5'h03, 6'h00, op_a, zero, 32'h12B37F81},
    '{PEBU_OP_UNSIGNED_BYTE_EXTEND_ADD, 5'h00, 6'h00, op_a, zero, 32'h12348086},
    '{PEBU_OP_UNSIGNED_HALF_EXTEND_ADD, 5'h01, 6'h00, op_a, zero, 32'h12357080},
    '{PEBU_OP_UNSIGNED_DUAL_BYTE_EXTEND_ADD, 5'h02, 6'h00, op_a, zero, 32'h12B980F1},
    '{PEBU_OP_SIGNED_BYTE_EXTEND, 5'h00, 6'h00, 32'h80F07F85, zero, 32'hFFFFFF85},
    '{PEBU_OP_SIGNED_HALF_EXTEND, 5'h03, 6'h00, 32'h80F07F85, zero, 32'hFFFF8580},
    '{PEBU_OP_SIGNED_DUAL_BYTE_EXTEND, 5'h01, 6'h00, 32'h80F07F85, zero, 32'hFF80007F},
    '{PEBU_OP_UNSIGNED_BYTE_EXTEND, 5'h02, 6'h00, 32'h80F07F85, zero, 32'h000000F0},
    '{PEBU_OP_UNSIGNED_HALF_EXTEND, 5'h00, 6'h00, 32'h80F07F85, zero, 32'h00007F85},
    '{PEBU_OP_UNSIGNED_DUAL_BYTE_EXTEND, 5'h03, 6'h00, 32'h80F07F85, zero, 32'h007F0080},
    '{PEBU_OP_FIELD_CLEAR, 5'h08, 6'h0C, op_a, ones, 32'hFFF000FF},
    '{PEBU_OP_FIELD_CLEAR, 5'h00, 6'h20, op_a, ones, 32'h00000000},
    '{PEBU_OP_FIELD_INSERT, 5'h1F, 6'h01, op_a, zero, 32'h80000000}};

  always #12.5 SYS_CLK_I = ~SYS_CLK_I;

  pebu_top u_pebu_top (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .REQ_VALID_I(REQ_VALID_I),
    .REQ_I(REQ_I), .RSP_O(RSP_O));
  pebu_regfile u_pebu_regfile (.clk_i(SYS_CLK_I), .rsp_i(RSP_O), .regs_o(regs));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task test_done;
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    REQ_I.first_idx = 4'h5;
    REQ_I.dest_idx = 4'h9;
    REQ_I.second_operand = 32'h80F07F85;
    repeat (2) @(negedge SYS_CLK_I);
    SYS_RST_I = 1'b0;
    for (int i = 0; i < 19; i++) begin
      REQ_VALID_I = 1'b1;
      REQ_I.op = rows[i].op;
      REQ_I.shift_amt = rows[i].amt;
      REQ_I.rot_sel = rows[i].amt[1:0];
      REQ_I.field_lsb = rows[i].amt;
      REQ_I.field_width = rows[i].wid;
      REQ_I.first_operand = rows[i].a;
      REQ_I.dest_value = rows[i].d;
      @(negedge SYS_CLK_I);
      chk("data", RSP_O.data, rows[i].exp);
      chk("wr_idx", 32'(RSP_O.wr_idx), (rows[i].op <= PEBU_OP_UNSIGNED_DUAL_BYTE_EXTEND_ADD) ? 32'h5 : 32'h9);
      chk("valid_flags", 32'({RSP_O.valid, RSP_O.flags_we}), 32'h2);
    end
    REQ_VALID_I = 1'b0;
    @(negedge SYS_CLK_I);
    chk("idle", 32'(RSP_O.valid), zero);
    chk("regfile", regs[5], 32'h12B980F1);
    REQ_VALID_I = 1'b1;
    REQ_I.op = PEBU_OP_PACK_TB;
    REQ_I.dest_given = 1'b1;
    @(negedge SYS_CLK_I);
    chk("dest", 32'(RSP_O.wr_idx), 32'h9);
    SYS_RST_I = 1'b1;
    @(negedge SYS_CLK_I);
    chk("reset", {RSP_O.valid, RSP_O.data[30:0]}, zero);
    SYS_RST_I = 1'b0;
    REQ_VALID_I = 1'b0;
    @(negedge SYS_CLK_I);
    chk("after_reset", 32'(RSP_O.valid), zero);
    test_done();
  end
endmodule : testbench
